// [rtl/bsctp_params.svh]
// Constants for the boundary-scan test port and its controller
`ifndef BSCTP_PARAMS_SVH
`define BSCTP_PARAMS_SVH
`define BSCTP_IR_LEN        10
`define BSCTP_DR_LEN        32
`define BSCTP_CHAIN_DEF     420
`define BSCTP_IR_EXTEST     10'h000
`define BSCTP_IR_SAMPLE     10'h005
`define BSCTP_IR_DEVICE_IDENTIFICATION     10'h006
`define BSCTP_IR_USER_CODE_WORD   10'h007
`define BSCTP_IR_CFG_LOAD   10'h002
`define BSCTP_IR_CFG_DONE   10'h003
`define BSCTP_IR_ANALYZER   10'h00E
`define BSCTP_IR_BYPASS     10'h3FF
`define BSCTP_IR_CAPTURE    10'h001
`define BSCTP_ID_VER_LSB    28
`define BSCTP_ID_PART_LSB   12
`define BSCTP_ID_MFR_LSB    1
`define BSCTP_TCK_HALF      4
`define BSCTP_REG_CMD       32'h0000_0000
`define BSCTP_REG_DATA      32'h0000_0004
`define BSCTP_REG_LEN       32'h0000_0008
`define BSCTP_REG_STATUS    32'h0000_000C
`define BSCTP_REG_RESULT    32'h0000_0010
`define BSCTP_CMD_RESET     2'h0
`define BSCTP_CMD_IR        2'h1
`define BSCTP_CMD_DR        2'h2
`endif

// [rtl/bsctp_pkg.sv]
// Types shared by both ends of the test port
package bsctp_pkg;
    typedef enum logic [3:0] {
        TLR, RTI, SDRS, CDR, SDR, E1DR, PDR, E2DR, UDR,
        SIRS, CIR, SIR, E1IR, PIR, E2IR, UIR
    } bsctp_tap_t;
    typedef enum logic [1:0] {
        SEL_BYPASS, SEL_ID, SEL_USER, SEL_CHAIN
    } bsctp_sel_t;
endpackage

// [rtl/bsctp_link_if.sv]
// Serial test-port link between controller and device
`timescale 1ns/1ps
`default_nettype none
interface bsctp_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdoOe_b;
    modport host (output tck, output tms, output tdi, input tdo, input tdoOe_b);
    modport dev  (input tck, input tms, input tdi, output tdo, output tdoOe_b);
endinterface // bsctp_link_if
`default_nettype wire

// [rtl/bsctp_device.sv]
// Device end: TAP state machine, instruction and data registers
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bsctp_params.svh"
module bsctp_device import bsctp_pkg::*; #(
    parameter int          CHAIN_LEN = `BSCTP_CHAIN_DEF,
    parameter bit          NO_BSCAN  = 1'b0,
    parameter logic [3:0]  ID_VER    = 4'h1,
    parameter logic [15:0] ID_PART   = 16'h1234,
    parameter logic [10:0] ID_MFR    = 11'h155,
    parameter logic [31:0] USER_CODE = 32'hCAFE_0001
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    // Link
    bsctp_link_if.dev                 link,
    // Pins under test
    input  wire logic [CHAIN_LEN-1:0] pinIn,
    output logic      [CHAIN_LEN-1:0] pinOut,
    output logic                      pinOverride,
    // Configuration and analyzer
    input  wire logic                 cfgBusy,
    output logic                      cfgBit,
    output logic                      cfgBitValid,
    output logic                      cfgStart,
    output logic                      cfgDone,
    input  wire logic [31:0]          probeIn
);
    // Arbitrary identity values above; not any real part
    localparam int CL = NO_BSCAN ? 1 : CHAIN_LEN;
    logic [2:0]               tckS_r;
    logic [2:0]               tmsS_r;
    logic [2:0]               tdiS_r;
    bsctp_tap_t               state_r;
    bsctp_tap_t               state_nxt;
    logic [`BSCTP_IR_LEN-1:0] irShift_r;
    logic [`BSCTP_IR_LEN-1:0] ir_r;
    logic [31:0]              drShift_r;
    logic [CL-1:0]            pinS1_r;
    logic [CL-1:0]            pinS2_r;
    logic [CL-1:0]            chain_r;
    logic [CL-1:0]            upd_r;
    logic [CL-1:0]            chainShift;
    logic                     bypass_r;
    logic                     tdo_r;
    logic                     oe_r;
    wire tckRise = tckS_r[1] & ~tckS_r[2];
    wire tckFall = ~tckS_r[1] & tckS_r[2];
    wire tms = tmsS_r[1];
    wire tdi = tdiS_r[1];

    // Chain shift; a one-cell chain has no upper part
    generate
        if (CL > 1) begin : g_chainLong
            assign chainShift = {tdi, chain_r[CL-1:1]};
        end else begin : g_chainOne
            assign chainShift = tdi;
        end
    endgenerate

    // ----------------------------------------
    // Instruction decode
    // ----------------------------------------
    function automatic bsctp_sel_t decode(input logic [`BSCTP_IR_LEN-1:0] i, input bit nb);
        if (nb) decode = SEL_BYPASS;
        else case (i)
            `BSCTP_IR_DEVICE_IDENTIFICATION:   decode = SEL_ID;
            `BSCTP_IR_USER_CODE_WORD: decode = SEL_USER;
            `BSCTP_IR_ANALYZER, `BSCTP_IR_CFG_LOAD: decode = SEL_USER;
            `BSCTP_IR_SAMPLE, `BSCTP_IR_EXTEST: decode = SEL_CHAIN;
            default:            decode = SEL_BYPASS;
        endcase
    endfunction
    wire bsctp_sel_t sel = decode(ir_r, NO_BSCAN);
    wire isAnalyzer = (ir_r == `BSCTP_IR_ANALYZER);
    wire isCfg = (ir_r == `BSCTP_IR_CFG_LOAD) & ~NO_BSCAN;
    wire isExtest = (ir_r == `BSCTP_IR_EXTEST) & ~NO_BSCAN;
    wire [31:0] idWord = {ID_VER, ID_PART, ID_MFR, 1'b1};

    // ----------------------------------------
    // TAP state machine
    // ----------------------------------------
    always_comb begin
        case (state_r)
            TLR:  state_nxt = tms ? TLR  : RTI;
            RTI:  state_nxt = tms ? SDRS : RTI;
            SDRS: state_nxt = tms ? SIRS : CDR;
            CDR:  state_nxt = tms ? E1DR : SDR;
            SDR:  state_nxt = tms ? E1DR : SDR;
            E1DR: state_nxt = tms ? UDR  : PDR;
            PDR:  state_nxt = tms ? E2DR : PDR;
            E2DR: state_nxt = tms ? UDR  : SDR;
            UDR:  state_nxt = tms ? SDRS : RTI;
            SIRS: state_nxt = tms ? TLR  : CIR;
            CIR:  state_nxt = tms ? E1IR : SIR;
            SIR:  state_nxt = tms ? E1IR : SIR;
            E1IR: state_nxt = tms ? UIR  : PIR;
            PIR:  state_nxt = tms ? E2IR : PIR;
            E2IR: state_nxt = tms ? UIR  : SIR;
            UIR:  state_nxt = tms ? SDRS : RTI;
            default: state_nxt = TLR;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tckS_r <= '0;
            tmsS_r <= 3'b111;
            tdiS_r <= '0;
            pinS1_r <= '0;
            pinS2_r <= '0;
        end else begin
            tckS_r <= {tckS_r[1:0], link.tck};
            tmsS_r <= {tmsS_r[1:0], link.tms};
            tdiS_r <= {tdiS_r[1:0], link.tdi};
            // Pin states pass two flops before capture
            pinS1_r <= pinIn[CL-1:0];
            pinS2_r <= pinS1_r;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) state_r <= TLR;
        else if (tckRise) state_r <= state_nxt;
    end

    // ----------------------------------------
    // Instruction register
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irShift_r <= '0;
            ir_r      <= `BSCTP_IR_DEVICE_IDENTIFICATION;
        end else if (tckRise) begin
            case (state_r)
                TLR: ir_r <= NO_BSCAN ? `BSCTP_IR_BYPASS : `BSCTP_IR_DEVICE_IDENTIFICATION;
                CIR: irShift_r <= `BSCTP_IR_CAPTURE;
                SIR: irShift_r <= {tdi, irShift_r[`BSCTP_IR_LEN-1:1]};
                UIR: ir_r <= irShift_r;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Data registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            drShift_r <= '0;
            bypass_r  <= 1'b0;
            chain_r   <= '0;
            upd_r     <= '0;
        end else if (tckRise) begin
            if (state_r == CDR) begin
                bypass_r  <= 1'b0;
                drShift_r <= (sel == SEL_ID) ? idWord :
                             isAnalyzer ? probeIn : USER_CODE;
                chain_r   <= pinS2_r;
            end else if (state_r == SDR) begin
                bypass_r  <= tdi;
                drShift_r <= {tdi, drShift_r[31:1]};
                chain_r   <= chainShift;
            end else if (state_r == UDR && sel == SEL_CHAIN) begin
                upd_r <= chain_r;
            end
        end
    end

    // ----------------------------------------
    // Configuration path and pin drive
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgBit      <= 1'b0;
            cfgBitValid <= 1'b0;
            cfgStart    <= 1'b0;
            cfgDone     <= 1'b0;
        end else begin
            cfgBitValid <= tckRise & isCfg & (state_r == SDR) & cfgBusy;
            cfgBit      <= tdi;
            cfgStart    <= tckRise & (state_r == UIR) & (irShift_r == `BSCTP_IR_CFG_LOAD)
                           & ~NO_BSCAN;
            cfgDone     <= tckRise & (state_r == UIR) & (irShift_r == `BSCTP_IR_CFG_DONE)
                           & ~NO_BSCAN;
        end
    end

    generate
        if (NO_BSCAN) begin : g_nobs
            assign pinOut = '0;
        end else begin : g_bs
            assign pinOut = upd_r;
        end
    endgenerate
    assign pinOverride = isExtest;

    // ----------------------------------------
    // Serial output on the falling test clock
    // ----------------------------------------
    wire tdoSel = (state_r == SIR) ? irShift_r[0] :
                  (sel == SEL_BYPASS) ? bypass_r :
                  (sel == SEL_CHAIN) ? chain_r[0] : drShift_r[0];
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tdo_r <= 1'b0;
            oe_r  <= 1'b1;
        end else if (tckFall) begin
            tdo_r <= tdoSel;
            oe_r  <= ~(state_r == SIR || state_r == SDR);
        end
    end
    assign link.tdo     = tdo_r;
    assign link.tdoOe_b = oe_r;
endmodule // bsctp_device
`default_nettype wire

// [rtl/bsctp_host.sv]
// Host end: AHB-Lite register slave driving scan sequences
`timescale 1ns/1ps
`default_nettype none
`include "bsctp_params.svh"
module bsctp_host import bsctp_pkg::*; #(
    parameter int TCK_HALF = `BSCTP_TCK_HALF
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Link
    bsctp_link_if.host       link
);
    typedef enum logic [2:0] {H_IDLE, H_HEAD, H_SHIFT, H_TAIL, H_RST} bsctp_hst_t;
    logic [31:0] data_r, result_r;
    logic [5:0]  len_r, cnt_r, hdrCnt_r;
    logic [1:0]  cmd_r;
    bsctp_hst_t  st_r;
    logic [7:0]  div_r;
    logic        tck_r, tms_r, tdi_r, wrPend_r, capPend_r;
    logic [7:0]  waddr_r;
    logic [1:0]  tdoS_r;
    wire busy = (st_r != H_IDLE);
    wire phase = hsel & hready & htrans[1];
    wire tick = (div_r == 8'(TCK_HALF - 1));
    wire fall = tick & tck_r;
    wire [7:0] a = haddr[7:0];

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPend_r <= 1'b0;
            waddr_r  <= '0;
            hrdata   <= '0;
        end else begin
            wrPend_r <= phase & hwrite;
            waddr_r  <= a;
            if (phase & ~hwrite) begin
                case (32'(a))
                    `BSCTP_REG_DATA:   hrdata <= data_r;
                    `BSCTP_REG_LEN:    hrdata <= {26'h000_0000, len_r};
                    `BSCTP_REG_STATUS: hrdata <= {31'h0000_0000, busy};
                    `BSCTP_REG_RESULT: hrdata <= result_r;
                    default:           hrdata <= '0;
                endcase
            end
        end
    end
    wire cmdWr = wrPend_r & (32'(waddr_r) == `BSCTP_REG_CMD) & ~busy;

    // ----------------------------------------
    // Clock divider and scan sequencer
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_r     <= '0;
            tck_r     <= 1'b0;
            tms_r     <= 1'b1;
            tdi_r     <= 1'b0;
            st_r      <= H_RST;
            cnt_r     <= '0;
            hdrCnt_r  <= '0;
            cmd_r     <= '0;
            data_r    <= '0;
            len_r     <= 6'd32;
            result_r  <= '0;
            tdoS_r    <= '0;
            capPend_r <= 1'b0;
        end else begin
            tdoS_r <= {tdoS_r[0], link.tdo};
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            if (wrPend_r && 32'(waddr_r) == `BSCTP_REG_DATA && !busy) data_r <= hwdata;
            if (wrPend_r && 32'(waddr_r) == `BSCTP_REG_LEN && !busy) len_r <= hwdata[5:0];
            if (tick) tck_r <= ~tck_r;
            if (cmdWr) begin
                cmd_r <= hwdata[1:0];
                hdrCnt_r <= '0;
                cnt_r <= '0;
                st_r <= (hwdata[1:0] == `BSCTP_CMD_RESET) ? H_RST : H_HEAD;
            end else if (fall) begin
                case (st_r)
                    H_RST: begin // Five high TMS clocks reach reset, then idle
                        tms_r <= (hdrCnt_r < 6'd5);
                        hdrCnt_r <= hdrCnt_r + 6'd1;
                        if (hdrCnt_r == 6'd5) st_r <= H_IDLE;
                    end
                    H_HEAD: begin // From idle: 1 (,1) 0 0 to shift state
                        hdrCnt_r <= hdrCnt_r + 6'd1;
                        if (cmd_r == `BSCTP_CMD_IR) tms_r <= (hdrCnt_r < 6'd2);
                        else tms_r <= (hdrCnt_r == 6'd0);
                        if ((cmd_r == `BSCTP_CMD_IR && hdrCnt_r == 6'd3) ||
                            (cmd_r == `BSCTP_CMD_DR && hdrCnt_r == 6'd2)) begin
                            st_r <= H_SHIFT;
                            tms_r <= 1'b0;
                        end
                    end
                    H_SHIFT: begin
                        tdi_r <= data_r[cnt_r[4:0]];
                        tms_r <= (cnt_r == len_r - 6'd1);
                        cnt_r <= cnt_r + 6'd1;
                        if (cnt_r == len_r - 6'd1) begin
                            st_r <= H_TAIL;
                            hdrCnt_r <= '0;
                        end
                    end
                    H_TAIL: begin // Update then back to idle
                        tms_r <= (hdrCnt_r == 6'd0);
                        hdrCnt_r <= hdrCnt_r + 6'd1;
                        if (hdrCnt_r == 6'd2) st_r <= H_IDLE;
                    end
                    default: ;
                endcase
            end
            // Bit driven after one falling edge is settled by the next
            if (fall) begin
                capPend_r <= (st_r == H_SHIFT);
                if (capPend_r) result_r <= {tdoS_r[1], result_r[31:1]};
            end
        end
    end
    assign link.tck = tck_r;
    assign link.tms = tms_r;
    assign link.tdi = tdi_r;
endmodule // bsctp_host
`default_nettype wire

// [verif/bsctp_link_sva.sv]
// Link checker: TAP tracking and timing relations on the serial link
`timescale 1ns/1ps
`default_nettype none
`include "bsctp_params.svh"
module bsctp_link_sva import bsctp_pkg::*; #(
    parameter int TCK_HALF = `BSCTP_TCK_HALF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Link
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdoOe_b
);
    // ------
    // Shadow TAP
    // ------
    logic       tckD_r;
    logic [7:0] levCnt_r;
    logic [5:0] irCnt_r;
    logic [5:0] drCnt_r;
    logic       idSel_r;
    bsctp_tap_t st_r;
    bsctp_tap_t st_nxt;
    wire logic  tckRise = tck & ~tckD_r;
    always_comb begin
        case (st_r)
            TLR:     st_nxt = tms ? TLR  : RTI;
            RTI:     st_nxt = tms ? SDRS : RTI;
            SDRS:    st_nxt = tms ? SIRS : CDR;
            CDR:     st_nxt = tms ? E1DR : SDR;
            SDR:     st_nxt = tms ? E1DR : SDR;
            E1DR:    st_nxt = tms ? UDR  : PDR;
            PDR:     st_nxt = tms ? E2DR : PDR;
            E2DR:    st_nxt = tms ? UDR  : SDR;
            SIRS:    st_nxt = tms ? TLR  : CIR;
            CIR:     st_nxt = tms ? E1IR : SIR;
            SIR:     st_nxt = tms ? E1IR : SIR;
            E1IR:    st_nxt = tms ? UIR  : PIR;
            PIR:     st_nxt = tms ? E2IR : PIR;
            E2IR:    st_nxt = tms ? UIR  : SIR;
            default: st_nxt = tms ? SDRS : RTI;
        endcase
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tckD_r <= 1'b0;
            levCnt_r <= 8'hFF;
            irCnt_r <= 6'h00;
            drCnt_r <= 6'h00;
            idSel_r <= 1'b1;
            st_r <= TLR;
        end else begin
            tckD_r <= tck;
            levCnt_r <= (tck != tckD_r) ? 8'h01 : levCnt_r + {7'h0, levCnt_r != 8'hFF};
            if (tckRise) begin
                st_r <= st_nxt;
                irCnt_r <= (st_r == SIR) ? irCnt_r + 6'h01 : ((st_r == CIR) ? 6'h00 : irCnt_r);
                drCnt_r <= (st_r == SDR) ? drCnt_r + 6'h01 : ((st_r == CDR) ? 6'h00 : drCnt_r);
                idSel_r <= (st_r == TLR) | (idSel_r & (st_r != UIR));
            end
        end
    end
    // ------
    // Assertions
    // ------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    AST_TCK_HIGH: assert property ($fell(tck) |-> levCnt_r == 8'(TCK_HALF))
        else $error("tck high phase length wrong");
    AST_TCK_LOW: assert property ($rose(tck) |-> levCnt_r >= 8'(TCK_HALF))
        else $error("tck low phase too short");
    AST_TMS_HOLD: assert property (tck && $past(tck) |-> $stable(tms) && $stable(tdi))
        else $error("tms or tdi moved while tck high");
    AST_TDO_FALL: assert property ($changed(tdo) |-> !tck)
        else $error("tdo changed while tck high");
    AST_OE_FALL: assert property ($changed(tdoOe_b) |-> !tck)
        else $error("tdo enable changed while tck high");
    AST_OE_SHIFT: assert property ($fell(tdoOe_b) |-> st_r == SDR || st_r == SIR)
        else $error("tdo driven outside shift states");
    AST_OE_ON: assert property ($fell(tck) && (st_r == SDR || st_r == SIR) |-> ##[1:4] !tdoOe_b)
        else $error("tdo not driven in shift state");
    AST_OE_OFF: assert property ($fell(tck) && (st_r == E1DR || st_r == E1IR) |-> ##[1:4] tdoOe_b)
        else $error("tdo not released after shift");
    AST_IR_LEN: assert property ($rose(st_r == E1IR) |-> irCnt_r == 6'h0A)
        else $error("instruction scan length not ten");
    AST_IR_CAPT: assert property (tckRise && st_r == SIR && irCnt_r < 6'h02 |-> tdo == (irCnt_r == 6'h00))
        else $error("instruction capture bits wrong");
    AST_ID_LSB: assert property (tckRise && st_r == SDR && drCnt_r == 6'h00 && idSel_r |-> tdo)
        else $error("first identification bit not one");
endmodule // bsctp_link_sva
`default_nettype wire

// [verif/bsctp_tb.sv]
// Testbench: AHB-Lite driven scans through host end into device end
`timescale 1ns/1ps
`default_nettype none
`include "bsctp_params.svh"
module bsctp_tb;
    // ------
    // Setup
    // ------
    localparam int          CHAIN = 16;
    localparam logic [3:0]  VER   = 4'h2;    // Arbitrary identity value
    localparam logic [15:0] PART  = 16'h5A3C; // Arbitrary identity value
    localparam logic [10:0] MFR   = 11'h0AB;  // Arbitrary identity value
    localparam logic [31:0] UCODE = 32'h1357_9BDF;
    localparam logic [31:0] ID    = {VER, PART, MFR, 1'b1};
    localparam int          LIMIT = 60000;
    logic             core_clk = 1'b0;
    logic             rst_b = 1'b0;
    logic             hsel = 1'b0;
    logic [31:0]      haddr = 32'h0000_0000;
    logic [1:0]       htrans = 2'b00;
    logic             hwrite = 1'b0;
    logic [2:0]       hsize = 3'b010;
    logic [31:0]      hwdata = 32'h0000_0000;
    wire logic [31:0] hrdata;
    wire logic        hreadyout;
    wire logic        hresp;
    logic [CHAIN-1:0] pinIn = 16'h0000;
    wire logic [CHAIN-1:0] pinOut;
    wire logic        pinOverride;
    logic             cfgBusy = 1'b0;
    wire logic        cfgBit;
    wire logic        cfgBitValid;
    wire logic        cfgStart;
    wire logic        cfgDone;
    wire logic [CHAIN-1:0] nbPinOut;
    wire logic        nbOverride;
    wire logic        nbCfgStart;
    wire logic        nbCfgValid;
    int nNbCfg = 0;
    logic [31:0]      probeIn = 32'h0000_0000;
    logic [7:0]       cfgWord = 8'h00;
    logic [31:0]      r;
    logic [9:0]       bypCode [2] = '{10'h3FF, 10'h155};
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    int nStart = 0;
    int nDone = 0;
    int nBits = 0;
    always #50 core_clk = ~core_clk;
    bsctp_link_if i_bsctp_link_if ();
    bsctp_host #(.TCK_HALF(`BSCTP_TCK_HALF)) i_bsctp_host (.core_clk(core_clk), .rst_b(rst_b),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .link(i_bsctp_link_if.host));
    bsctp_device #(.CHAIN_LEN(CHAIN), .NO_BSCAN(1'b0), .ID_VER(VER), .ID_PART(PART),
        .ID_MFR(MFR), .USER_CODE(UCODE)) i_bsctp_device (.core_clk(core_clk), .rst_b(rst_b),
        .link(i_bsctp_link_if.dev), .pinIn(pinIn), .pinOut(pinOut), .pinOverride(pinOverride),
        .cfgBusy(cfgBusy), .cfgBit(cfgBit), .cfgBitValid(cfgBitValid), .cfgStart(cfgStart),
        .cfgDone(cfgDone), .probeIn(probeIn));
    // Member without boundary scan listens on a copy of the link
    bsctp_link_if i_bsctp_link_if_nb ();
    assign i_bsctp_link_if_nb.tck = i_bsctp_link_if.tck;
    assign i_bsctp_link_if_nb.tms = i_bsctp_link_if.tms;
    assign i_bsctp_link_if_nb.tdi = i_bsctp_link_if.tdi;
    bsctp_device #(.CHAIN_LEN(CHAIN), .NO_BSCAN(1'b1)) i_bsctp_device_nb (.core_clk(core_clk),
        .rst_b(rst_b), .link(i_bsctp_link_if_nb.dev), .pinIn(pinIn), .pinOut(nbPinOut),
        .pinOverride(nbOverride), .cfgBusy(cfgBusy), .cfgBit(), .cfgBitValid(nbCfgValid),
        .cfgStart(nbCfgStart), .cfgDone(), .probeIn(probeIn));
    bsctp_link_sva #(.TCK_HALF(`BSCTP_TCK_HALF)) i_bsctp_link_sva (.core_clk(core_clk),
        .rst_b(rst_b), .tck(i_bsctp_link_if.tck), .tms(i_bsctp_link_if.tms),
        .tdi(i_bsctp_link_if.tdi), .tdo(i_bsctp_link_if.tdo), .tdoOe_b(i_bsctp_link_if.tdoOe_b));
    // ------
    // Tasks and monitors
    // ------
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic ahbXfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                           output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
        if (hresp !== 1'b0) check({31'h0, hresp}, 32'h0000_0000, "bus response");
    endtask
    task automatic waitIdle();
        logic [31:0] st;
        st = 32'h0000_0001;
        while (st[0] !== 1'b0) ahbXfer(1'b0, `BSCTP_REG_STATUS, 32'h0000_0000, st);
    endtask
    task automatic scan(input logic [1:0] cmd, input logic [5:0] len, input logic [31:0] d,
                        output logic [31:0] res);
        logic [31:0] tmp;
        ahbXfer(1'b1, `BSCTP_REG_DATA, d, tmp);
        ahbXfer(1'b1, `BSCTP_REG_LEN, {26'h0, len}, tmp);
        ahbXfer(1'b1, `BSCTP_REG_CMD, {30'h0, cmd}, tmp);
        waitIdle();
        ahbXfer(1'b0, `BSCTP_REG_RESULT, 32'h0000_0000, res);
        res = res >> (6'h20 - len);
    endtask
    task automatic instr(input logic [9:0] code);
        logic [31:0] tmp;
        scan(`BSCTP_CMD_IR, 6'h0A, {22'h0, code}, tmp);
        check({30'h0, tmp[1:0]}, 32'h0000_0001, "instruction capture");
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cfgStart === 1'b1) nStart++;
        if (cfgDone === 1'b1) nDone++;
        if (nbCfgStart === 1'b1 || nbCfgValid === 1'b1) nNbCfg++;
        if (cfgBitValid === 1'b1) begin
            nBits++;
            cfgWord = {cfgBit, cfgWord[7:1]};
        end
        if (cycles == LIMIT) begin
            n_mismatch++;
            conclude();
        end
    end
    // ------
    // Sequence
    // ------
    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        waitIdle();
        scan(`BSCTP_CMD_DR, 6'h20, 32'h0000_0000, r);
        check(r, ID, "id after reset");
        instr(`BSCTP_IR_DEVICE_IDENTIFICATION);
        scan(`BSCTP_CMD_DR, 6'h20, 32'h0000_0000, r);
        check(r, ID, "id by instruction");
        instr(`BSCTP_IR_USER_CODE_WORD);
        scan(`BSCTP_CMD_DR, 6'h20, 32'h0000_0000, r);
        check(r, UCODE, "user code");
        $display("test identity done");
        foreach (bypCode[i]) begin
            instr(bypCode[i]);
            scan(`BSCTP_CMD_DR, 6'h08, 32'h0000_00A5, r);
            check(r, 32'h0000_004A, "one bit delay");
        end
        $display("test bypass done");
        pinIn <= 16'hC3A5;
        instr(`BSCTP_IR_SAMPLE);
        check({31'h0, pinOverride}, 32'h0000_0000, "sample leaves pins");
        scan(`BSCTP_CMD_DR, 6'h10, 32'h0000_0F0F, r);
        check(r, 32'h0000_C3A5, "sampled pins");
        instr(`BSCTP_IR_EXTEST);
        check({31'h0, pinOverride}, 32'h0000_0001, "extest drives");
        check({16'h0, pinOut}, 32'h0000_0F0F, "preloaded pattern");
        check({15'h0, nbOverride, nbPinOut}, 32'h0000_0000, "no scan member pins");
        pinIn <= 16'h00FF;
        scan(`BSCTP_CMD_DR, 6'h10, 32'h0000_1234, r);
        check(r, 32'h0000_00FF, "extest capture");
        check({16'h0, pinOut}, 32'h0000_1234, "extest pattern");
        scan(`BSCTP_CMD_DR, 6'h11, 32'h0000_0001, r);
        check(r, 32'h0001_00FF, "chain length");
        scan(`BSCTP_CMD_RESET, 6'h20, 32'h0000_0000, r);
        check({31'h0, pinOverride}, 32'h0000_0000, "reset frees pins");
        $display("test boundary done");
        probeIn <= 32'hDEAD_BEEF;
        instr(`BSCTP_IR_ANALYZER);
        scan(`BSCTP_CMD_DR, 6'h20, 32'h0000_0000, r);
        check(r, 32'hDEAD_BEEF, "probe capture");
        $display("test analyzer done");
        // Config session only after all boundary-scan work
        cfgBusy <= 1'b1;
        instr(`BSCTP_IR_CFG_LOAD);
        check(32'(nStart), 32'h0000_0001, "config start");
        scan(`BSCTP_CMD_DR, 6'h08, 32'h0000_0096, r);
        check(32'(nBits), 32'h0000_0008, "config bit count");
        check({24'h0, cfgWord}, 32'h0000_0096, "config bits");
        instr(`BSCTP_IR_CFG_DONE);
        check(32'(nDone), 32'h0000_0001, "config done");
        check(32'(nNbCfg), 32'h0000_0000, "no scan member config");
        cfgBusy <= 1'b0;
        ahbXfer(1'b0, 32'h0000_0020, 32'h0000_0000, r);
        check(r, 32'h0000_0000, "unmapped read");
        $display("test config done");
        conclude();
    end
endmodule // bsctp_tb
`default_nettype wire
